// ### cfg_loader_pkg.sv
package cfg_loader_pkg;
    // program memory word addresses of the packed configuration
    localparam logic [23:0] ADDR_WORD_ONE  = 24'h0157fe;
    localparam logic [23:0] ADDR_WORD_TWO  = 24'h0157fc;
    localparam logic [23:0] ADDR_WORD_LAST = 24'h0157f8;
    localparam int          WORD_W         = 24;
    // erased flash reads all ones in the upper byte field
    localparam logic [7:0]  UNIMPL_FILL    = 8'hff;
    // word one field positions
    localparam int W1_RSVD     = 15;
    localparam int W1_TESTPORT = 14;
    localparam int W1_CODEGRD  = 13;
    localparam int W1_WRGRD    = 12;
    localparam int W1_DEBUG    = 11;
    localparam int W1_RETCFG   = 10;
    localparam int W1_EMU_LO   = 8;
    localparam int W1_WDEN_LO  = 6;
    localparam int W1_WINDOW_DISABLE   = 5;
    localparam int W1_PRESC    = 4;
    localparam int W1_POST_LO  = 0;
    // word two field positions
    localparam int W2_TWOSPEED = 15;
    localparam int W2_VBATBOR  = 14;
    localparam int W2_WDCMX    = 13;
    localparam int W2_CMPREF   = 12;
    localparam int W2_ADCREF   = 11;
    localparam int W2_OSC_LO   = 8;
    localparam int W2_CKSM_LO  = 6;
    localparam int W2_OSCOUT   = 5;
    localparam int W2_WDCLK_LO = 3;
    localparam int W2_POSC_LO  = 0;
    // unprogrammed (all ones) decoded flags; unused, dec_reg resets to 16'h0000 before a load completes
    localparam logic [15:0] CFG_RESET = 16'hffff;
    // flash read latency in cycles
    localparam logic [1:0]  FLASH_LAT = 2'd2;
    // decoded watchdog clock sources
    localparam logic [1:0] WDCLK_LOW_POWER_RC_OSC = 2'd0;
    localparam logic [1:0] WDCLK_FRC  = 2'd1;
    localparam logic [1:0] WDCLK_SECONDARY_OSC = 2'd2;
    localparam logic [1:0] WDCLK_SYS  = 2'd3;
endpackage

// ### flash_rd_if.sv
`timescale 1ns/1ps
`default_nettype none
interface flash_rd_if;
    logic        req;
    logic [23:0] addr;
    logic        valid;
    logic [23:0] data;
    modport master (output req, output addr, input valid, input data);
    modport slave  (input req, input addr, output valid, output data);
endinterface
`default_nettype wire

// ### flash_port.sv
`timescale 1ns/1ps
`default_nettype none
// adapts the single-request flash read pins to a fixed-latency handshake
module flash_port
    import cfg_loader_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst,
    flash_rd_if.slave        rd,
    output logic             flash_rd_en,
    output logic [23:0]      flash_addr,
    input  wire logic [23:0] flash_rdata
);
    logic [1:0]  cnt_reg, cnt_next;
    logic        en_reg, en_next;
    logic [23:0] addr_reg, addr_next;

    // count the fixed read latency after a request
    always_comb begin
        cnt_next  = cnt_reg;
        en_next   = 1'b0;
        addr_next = addr_reg;
        if (rd.req && cnt_reg == 2'd0) begin
            cnt_next  = FLASH_LAT;
            en_next   = 1'b1;
            addr_next = rd.addr;
        end else if (cnt_reg != 2'd0) begin
            cnt_next = cnt_reg - 2'd1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            cnt_reg  <= 2'd0;
            en_reg   <= 1'b0;
            addr_reg <= 24'h000000;
        end else begin
            cnt_reg  <= cnt_next;
            en_reg   <= en_next;
            addr_reg <= addr_next;
        end
    end

    assign flash_rd_en = en_reg;
    assign flash_addr  = addr_reg;
    assign rd.valid    = (cnt_reg == 2'd1);
    assign rd.data     = flash_rdata;
endmodule
`default_nettype wire

// ### config_word_loader.sv
`timescale 1ns/1ps
`default_nettype none
module config_word_loader
    import cfg_loader_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst,
    output logic             flash_rd_en,
    output logic [23:0]      flash_addr,
    input  wire logic [23:0] flash_rdata,
    input  wire logic        sys_clk_is_low_power_rc_osc,
    input  wire logic        in_sleep,
    input  wire logic        retention_enable_fw,
    input  wire logic        watchdog_software_enable,
    output logic             load_done,
    output logic [23:0]      config_word_one,
    output logic [23:0]      config_word_two,
    output logic             test_port_enable,
    output logic             code_protect_on,
    output logic             program_write_allow,
    output logic             debug_mode_entry,
    output logic             retention_regulator_on,
    output logic [1:0]       emulator_pin_pair,
    output logic             emulator_select_bad,
    output logic             watchdog_on,
    output logic             watchdog_run_only,
    output logic             watchdog_windowed,
    output logic             watchdog_prescale_128,
    output logic [15:0]      watchdog_postscale_ratio,
    output logic             two_speed_startup_select,
    output logic             backup_supply_brownout_enable,
    output logic             comparator_ref_pin_select,
    output logic             converter_ref_pin_select,
    output logic [2:0]       initial_oscillator_field,
    output logic             oscillator_select_bad,
    output logic             clock_switch_enable,
    output logic             fail_safe_monitor_enable,
    output logic [1:0]       watchdog_clock_source,
    output logic [1:0]       primary_osc_mode_field,
    output logic             osc_output_clock
);
    import cfg_loader_pkg::*;

    // one-hot load sequence
    typedef enum logic [3:0] {
        ST_READ_ONE = 4'b0001,
        ST_READ_TWO = 4'b0010,
        ST_DECODE   = 4'b0100,
        ST_DONE     = 4'b1000
    } load_state_e;

    flash_rd_if rd ();

    // sequencer state and the raw words
    load_state_e state_reg, state_next;
    logic        req_reg, req_next;
    logic [23:0] w1_reg, w1_next;
    logic [23:0] w2_reg, w2_next;
    logic        done_reg, done_next;

    // decoded settings, one flop per output
    logic [15:0] dec_reg, dec_next;
    logic [1:0]  emu_reg, emu_next;
    logic [15:0] post_reg, post_next;
    logic [2:0]  osc_reg, osc_next;
    logic [1:0]  wdclk_reg, wdclk_next;
    logic [1:0]  posc_reg, posc_next;
    logic        esb_reg, esb_next;
    logic        osb_reg, osb_next;

    // field slices read by the decoder
    logic [1:0]  wden;
    logic [1:0]  ck;

    // fixed-latency flash read adapter
    flash_port u_port (
        .clock       (clock),
        .rst         (rst),
        .rd          (rd.slave),
        .flash_rd_en (flash_rd_en),
        .flash_addr  (flash_addr),
        .flash_rdata (flash_rdata)
    );

    // request toward the flash adapter; address follows the state
    assign rd.req  = req_reg;
    assign rd.addr = (state_reg == ST_READ_ONE) ? ADDR_WORD_ONE : ADDR_WORD_TWO;

    // watchdog and clock switch fields of the loaded words
    assign wden    = w1_reg[W1_WDEN_LO +: 2];
    assign ck      = w2_reg[W2_CKSM_LO +: 2];

    // load sequencer; reset restarts it, so every reset reloads
    always_comb begin
        state_next = state_reg;
        req_next   = 1'b0;
        w1_next    = w1_reg;
        w2_next    = w2_reg;
        done_next  = done_reg;
        case (state_reg)
            ST_READ_ONE: begin
                req_next = !rd.valid;
                if (rd.valid) begin
                    w1_next    = {UNIMPL_FILL, rd.data[15:0]};
                    state_next = ST_READ_TWO;
                end
            end
            ST_READ_TWO: begin
                req_next = !rd.valid && !req_reg;
                if (rd.valid) begin
                    w2_next    = {UNIMPL_FILL, rd.data[15:0]};
                    state_next = ST_DECODE;
                end
            end
            ST_DECODE: begin
                state_next = ST_DONE;
            end
            ST_DONE: begin
                done_next = 1'b1;
            end
            default: state_next = ST_READ_ONE;
        endcase
    end

    // field decode; an erased word (all ones) decodes as unprotected
    always_comb begin
        dec_next   = dec_reg;
        emu_next   = emu_reg;
        post_next  = post_reg;
        osc_next   = osc_reg;
        wdclk_next = wdclk_reg;
        posc_next  = posc_reg;
        esb_next   = esb_reg;
        osb_next   = osb_reg;
        if (state_reg == ST_DECODE) begin
            dec_next[0]  = w1_reg[W1_TESTPORT];
            dec_next[1]  = !w1_reg[W1_CODEGRD];
            dec_next[2]  = w1_reg[W1_WRGRD];
            dec_next[3]  = !w1_reg[W1_DEBUG];
            // regulator off when one, on when zero
            dec_next[4]  = !w1_reg[W1_RETCFG];
            dec_next[5]  = (wden != 2'b00);
            dec_next[6]  = (wden == 2'b01);
            dec_next[7]  = !w1_reg[W1_WINDOW_DISABLE] && (wden != 2'b00);
            dec_next[8]  = w1_reg[W1_PRESC];
            dec_next[9]  = w2_reg[W2_TWOSPEED];
            dec_next[10] = w2_reg[W2_VBATBOR];
            dec_next[11] = w2_reg[W2_CMPREF];
            dec_next[12] = w2_reg[W2_ADCREF];
            // 1x disables both, 01 switching only
            dec_next[13] = !ck[1];
            dec_next[14] = (ck == 2'b00);
            // clock out only for modes 11 or 00
            dec_next[15] = w2_reg[W2_OSCOUT] &&
                           (w2_reg[W2_POSC_LO +: 2] == 2'b11 ||
                            w2_reg[W2_POSC_LO +: 2] == 2'b00);
            emu_next  = 2'd3 - w1_reg[W1_EMU_LO +: 2] + 2'd1;
            esb_next  = (w1_reg[W1_EMU_LO +: 2] == 2'b00);
            // ratio is two to the field value
            post_next = 16'h0001 << w1_reg[W1_POST_LO +: 4];
            osc_next  = w2_reg[W2_OSC_LO +: 3];
            osb_next  = (w2_reg[W2_OSC_LO +: 3] == 3'b110);
            posc_next = w2_reg[W2_POSC_LO +: 2];
            wdclk_next = WDCLK_LOW_POWER_RC_OSC;
            if (w2_reg[W2_WDCMX]) begin
                case (w2_reg[W2_WDCLK_LO +: 2])
                    2'b11: wdclk_next = WDCLK_LOW_POWER_RC_OSC;
                    2'b10: wdclk_next = (!w1_reg[W1_WINDOW_DISABLE] && !sys_clk_is_low_power_rc_osc)
                                        ? WDCLK_FRC : WDCLK_LOW_POWER_RC_OSC;
                    2'b01: wdclk_next = WDCLK_SECONDARY_OSC;
                    2'b00: wdclk_next = WDCLK_SYS;
                    default: wdclk_next = WDCLK_LOW_POWER_RC_OSC;
                endcase
            end
        end
    end

    // volatile words set to all ones and reloaded on every reset
    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= ST_READ_ONE;
            req_reg   <= 1'b0;
            w1_reg    <= 24'hffffff;
            w2_reg    <= 24'hffffff;
            done_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            req_reg   <= req_next;
            w1_reg    <= w1_next;
            w2_reg    <= w2_next;
            done_reg  <= done_next;
        end
    end

    // decoded settings change only at the decode step
    always_ff @(posedge clock) begin
        if (rst) begin
            dec_reg   <= 16'h0000;
            emu_reg   <= 2'd0;
            post_reg  <= 16'h0001;
            osc_reg   <= 3'd0;
            wdclk_reg <= WDCLK_LOW_POWER_RC_OSC;
            posc_reg  <= 2'b11;
            esb_reg   <= 1'b0;
            osb_reg   <= 1'b0;
        end else begin
            dec_reg   <= dec_next;
            emu_reg   <= emu_next;
            post_reg  <= post_next;
            osc_reg   <= osc_next;
            wdclk_reg <= wdclk_next;
            posc_reg  <= posc_next;
            esb_reg   <= esb_next;
            osb_reg   <= osb_next;
        end
    end

    // outputs straight from flops; consumers wait for load_done
    assign load_done                     = done_reg;
    assign config_word_one               = w1_reg;
    assign config_word_two               = w2_reg;

    // protection, debug, retention regulator and emulator settings
    assign test_port_enable              = dec_reg[0];
    assign code_protect_on               = dec_reg[1];
    assign program_write_allow           = dec_reg[2];
    assign debug_mode_entry              = dec_reg[3];
    assign retention_regulator_on        = dec_reg[4];
    assign emulator_pin_pair             = emu_reg;
    assign emulator_select_bad           = esb_reg;

    // watchdog settings
    assign watchdog_on                   = dec_reg[5];
    assign watchdog_run_only             = dec_reg[6];
    assign watchdog_windowed             = dec_reg[7];
    assign watchdog_prescale_128         = dec_reg[8];
    assign watchdog_postscale_ratio      = post_reg;
    assign watchdog_clock_source         = wdclk_reg;

    // supply and reference pin settings
    assign backup_supply_brownout_enable = dec_reg[10];
    assign comparator_ref_pin_select     = dec_reg[11];
    assign converter_ref_pin_select      = dec_reg[12];

    // oscillator and clock switch settings
    assign two_speed_startup_select      = dec_reg[9];
    assign initial_oscillator_field      = osc_reg;
    assign oscillator_select_bad         = osb_reg;
    assign clock_switch_enable           = dec_reg[13];
    assign fail_safe_monitor_enable      = dec_reg[14];
    assign primary_osc_mode_field        = posc_reg;
    assign osc_output_clock              = dec_reg[15];
endmodule
`default_nettype wire

// ### flash_model.sv
`timescale 1ns/1ps
`default_nettype none
// program flash holding both packed words, one-cycle read
module flash_model
    import cfg_loader_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rd_en,
    input  wire logic [23:0] addr,
    input  wire logic [23:0] word_one,
    input  wire logic [23:0] word_two,
    output logic [23:0]      rdata
);
    logic hold_reg;
    initial begin
        rdata = 24'h000000;
        hold_reg = 1'b0;
    end
    // words at the top addresses, others read garbage
    // data stands one cycle, then flips so stale data never matches
    always @(posedge clock) begin
        hold_reg <= rd_en;
        if (rd_en) begin
            rdata <= (addr === ADDR_WORD_ONE) ? word_one :
                     (addr === ADDR_WORD_TWO) ? word_two : ~rdata;
        end else if (hold_reg) begin
            rdata <= ~rdata;
        end
    end
endmodule
`default_nettype wire

// ### config_word_loader_chk.sv
`timescale 1ns/1ps
`default_nettype none
module config_word_loader_chk
    import cfg_loader_pkg::*;
(
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        flash_rd_en,
    input wire logic [23:0] flash_addr,
    input wire logic        load_done,
    input wire logic [23:0] config_word_one,
    input wire logic [23:0] config_word_two,
    input wire logic        code_protect_on,
    input wire logic        program_write_allow,
    input wire logic [1:0]  emulator_pin_pair,
    input wire logic [15:0] watchdog_postscale_ratio,
    input wire logic        clock_switch_enable,
    input wire logic        fail_safe_monitor_enable,
    input wire logic [2:0]  initial_oscillator_field,
    input wire logic        oscillator_select_bad
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // the two reads of one load
    sequence s_ask_one;
        flash_rd_en && flash_addr == ADDR_WORD_ONE;
    endsequence
    sequence s_ask_two;
        flash_rd_en && flash_addr == ADDR_WORD_TWO;
    endsequence
    a_read_order: assert property (s_ask_one |-> ##[1:8] s_ask_two)
        else $error("word two not fetched after word one");
    a_load_in_time: assert property ($fell(rst) |-> ##[1:30] load_done)
        else $error("load did not finish after reset");
    a_values_hold: assert property (load_done |=> load_done &&
        $stable(config_word_one) && $stable(config_word_two))
        else $error("loaded values changed without reset");
    a_upper_ones: assert property (load_done |-> config_word_one[23:16] == UNIMPL_FILL
        && config_word_two[23:16] == UNIMPL_FILL)
        else $error("upper byte not all ones");
    a_guard_bits: assert property (load_done |->
        code_protect_on == !config_word_one[13] && program_write_allow == config_word_one[12])
        else $error("guard decode wrong");
    a_emulator_pair: assert property (load_done |->
        emulator_pin_pair == 2'(3'h4 - config_word_one[9:8]))
        else $error("emulator pair wrong");
    a_postscale_ratio: assert property (load_done |->
        watchdog_postscale_ratio == 16'h0001 << config_word_one[3:0])
        else $error("postscale ratio wrong");
    a_clock_switch: assert property (load_done |->
        clock_switch_enable == !config_word_two[7]
        && fail_safe_monitor_enable == (config_word_two[7:6] == 2'h0))
        else $error("clock switch decode wrong");
    a_osc_reserved: assert property (load_done |->
        initial_oscillator_field == config_word_two[10:8]
        && oscillator_select_bad == (config_word_two[10:8] == 3'h6))
        else $error("oscillator select decode wrong");
endmodule
bind config_word_loader config_word_loader_chk config_word_loader_chk_i (
    .clock(clock), .rst(rst), .flash_rd_en(flash_rd_en), .flash_addr(flash_addr),
    .load_done(load_done), .config_word_one(config_word_one),
    .config_word_two(config_word_two), .code_protect_on(code_protect_on),
    .program_write_allow(program_write_allow), .emulator_pin_pair(emulator_pin_pair),
    .watchdog_postscale_ratio(watchdog_postscale_ratio),
    .clock_switch_enable(clock_switch_enable),
    .fail_safe_monitor_enable(fail_safe_monitor_enable),
    .initial_oscillator_field(initial_oscillator_field),
    .oscillator_select_bad(oscillator_select_bad));
`default_nettype wire

// ### config_word_loader_test.sv
`timescale 1ns/1ps
`default_nettype none
module config_word_loader_test;
    import cfg_loader_pkg::*;
    logic        clock, rst, rd_en, low_power_rc_osc, sleep_in, ret_fw, sw_wden, done;
    logic [23:0] addr, rdata, w1_in, w2_in, cw1, cw2;
    logic        tpe, cpo, pwa, dme, rro, esb, wdo, wdr, wdw, wp128, tss, bbe;
    logic        crp, arp, osb, cse, fsm, ooc;
    logic [1:0]  epp, wcs, pom;
    logic [15:0] wpr;
    logic [2:0]  iof;
    logic [15:0] ta [8];
    logic [15:0] tw [8];
    int          bad_count, checked, cycles;
    config_word_loader config_word_loader_i (.clock(clock), .rst(rst), .flash_rd_en(rd_en),
        .flash_addr(addr), .flash_rdata(rdata), .sys_clk_is_low_power_rc_osc(low_power_rc_osc), .in_sleep(sleep_in),
        .retention_enable_fw(ret_fw), .watchdog_software_enable(sw_wden), .load_done(done),
        .config_word_one(cw1), .config_word_two(cw2), .test_port_enable(tpe),
        .code_protect_on(cpo), .program_write_allow(pwa), .debug_mode_entry(dme),
        .retention_regulator_on(rro), .emulator_pin_pair(epp), .emulator_select_bad(esb),
        .watchdog_on(wdo), .watchdog_run_only(wdr), .watchdog_windowed(wdw),
        .watchdog_prescale_128(wp128), .watchdog_postscale_ratio(wpr),
        .two_speed_startup_select(tss), .backup_supply_brownout_enable(bbe),
        .comparator_ref_pin_select(crp), .converter_ref_pin_select(arp),
        .initial_oscillator_field(iof), .oscillator_select_bad(osb),
        .clock_switch_enable(cse), .fail_safe_monitor_enable(fsm),
        .watchdog_clock_source(wcs), .primary_osc_mode_field(pom), .osc_output_clock(ooc));
    flash_model flash_model_i (.clock(clock), .rd_en(rd_en), .addr(addr),
        .word_one(w1_in), .word_two(w2_in), .rdata(rdata));
    // free-running clock, 50 ns period
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // hang guard, far above the fewer than two hundred cycles needed
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            bad_count++;
            stop_test;
        end
    end
    task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic do_reset;
        rst = 1'b1;
        repeat (4) @(negedge clock);
        rst = 1'b0;
    endtask
    task automatic wait_done;
        int n;
        n = 0;
        while (done !== 1'b1 && n < 40) begin
            @(negedge clock);
            n++;
        end
        chk("load_done", done, 1'b1);
    endtask
    // outputs while reset is held
    task automatic t_reset_state;
        rst = 1'b1;
        repeat (4) @(negedge clock);
        chk("done_in_rst", done, 1'b0);
        chk("word_in_rst", cw1, 24'hffffff);
        chk("word2_in_rst", cw2, 24'hffffff);
    endtask
    // load one word pair and check every decoded field
    task automatic t_decode(input logic [15:0] a, input logic [15:0] b, input logic up,
                            input logic lp);
        logic [1:0] src;
        // upper byte zero as software should; 5a shows it is ignored
        w1_in = {up ? 8'h5a : 8'h00, a};
        w2_in = {up ? 8'h5a : 8'h00, b};
        low_power_rc_osc = lp;
        do_reset;
        wait_done;
        src = !b[13] || b[4:3] == 2'h3 ? WDCLK_LOW_POWER_RC_OSC : b[4:3] == 2'h1 ? WDCLK_SECONDARY_OSC :
              b[4:3] == 2'h0 ? WDCLK_SYS : (!a[5] && !lp) ? WDCLK_FRC : WDCLK_LOW_POWER_RC_OSC;
        chk("word_one", cw1, {8'hff, a});
        chk("word_two", cw2, {8'hff, b});
        chk("test_port", tpe, a[14]);
        chk("code_prot", cpo, !a[13]);
        chk("wr_allow", pwa, a[12]);
        chk("debug", dme, !a[11]);
        chk("ret_reg", rro, !a[10]);
        chk("emu_pair", epp, 2'(3'h4 - a[9:8]));
        chk("emu_bad", esb, a[9:8] == 2'h0);
        chk("wd_on", wdo, a[7:6] != 2'h0);
        chk("wd_run", wdr, a[7:6] == 2'h1);
        chk("wd_win", wdw, !a[5] && a[7:6] != 2'h0);
        chk("presc", wp128, a[4]);
        chk("postsc", wpr, 16'h0001 << a[3:0]);
        chk("two_speed", tss, b[15]);
        chk("vbat_bor", bbe, b[14]);
        chk("ref_pins", {crp, arp}, b[12:11]);
        chk("osc_sel", iof, b[10:8]);
        chk("osc_bad", osb, b[10:8] == 3'h6);
        chk("clk_sw", cse, !b[7]);
        chk("fscm", fsm, b[7:6] == 2'h0);
        chk("wd_clk", wcs, src);
        chk("posc", pom, b[1:0]);
        chk("osc_out", ooc, b[5] && (b[1:0] == 2'h3 || b[1:0] == 2'h0));
    endtask
    // flash and side inputs change after load; nothing may follow
    task automatic t_hold;
        w1_in = 24'h001234;
        w2_in = 24'h004321;
        {sleep_in, ret_fw, sw_wden} = 3'h7;
        repeat (20) @(negedge clock);
        chk("hold_one", cw1, {8'hff, ta[7]});
        chk("hold_two", cw2, {8'hff, tw[7]});
        chk("hold_done", done, 1'b1);
    endtask
    // reset cut into a running load, then a clean reload
    task automatic t_abort;
        do_reset;
        repeat (2) @(negedge clock);
        do_reset;
        wait_done;
        chk("reload_one", cw1, 24'hff1234);
        chk("reload_two", cw2, 24'hff4321);
    endtask
    initial begin
        {rst, low_power_rc_osc, sleep_in, ret_fw, sw_wden} = 5'h10;
        {w1_in, w2_in, bad_count, checked, cycles} = '0;
        ta = '{16'h0000, 16'hffff, 16'h2a95, 16'h5149, 16'h0c2a, 16'hffdf, 16'h4c70, 16'h3b8f};
        tw = '{16'h0000, 16'hffff, 16'h2292, 16'hb369, 16'h6c20, 16'h25b2, 16'h064b, 16'h8100};
        t_reset_state;
        for (int i = 0; i < 8; i++) begin
            t_decode(ta[i], tw[i], i[0], i == 5);
        end
        t_hold;
        t_abort;
        stop_test;
    end
endmodule
`default_nettype wire
